// ==== verilog/rtcaw_consts.svh ====
`ifndef RTCAW_CONSTS_SVH
`define RTCAW_CONSTS_SVH

// ==========================================================
// register offsets
`define RTCAW_OFS_FLAGS 4'h0
`define RTCAW_OFS_ALM_SEC 4'h2
`define RTCAW_OFS_ALM_MIN 4'h3
`define RTCAW_OFS_ALM_HOUR 4'h4
`define RTCAW_OFS_ALM_DATE 4'h5
`define RTCAW_OFS_IRQ 4'h6
`define RTCAW_OFS_WDOG 4'h7
`define RTCAW_OFS_TRIM 4'h8

// ==========================================================
// field positions
`define RTCAW_FLG_WDF 7
`define RTCAW_FLG_AF 6
`define RTCAW_FLG_PF 5
`define RTCAW_FLG_CAL 2
`define RTCAW_FLG_WEN 1
`define RTCAW_FLG_RD 0
`define RTCAW_IRQ_WIE 7
`define RTCAW_IRQ_AIE 6
`define RTCAW_IRQ_PFE 5
`define RTCAW_IRQ_SQUARE_OUTPUT_ENABLE 4
`define RTCAW_IRQ_HL 3
`define RTCAW_IRQ_PL 2
`define RTCAW_WD_KICK 7
`define RTCAW_WD_LOCK 6
`define RTCAW_TRIM_SIGN 5
`define RTCAW_ALM_MATCH 7

// ==========================================================
// reset values
`define RTCAW_RST_IRQ 8'h08
`define RTCAW_RST_WDOG 6'h00
`define RTCAW_RST_TRIM 8'h00
`define RTCAW_RST_ALM 8'h00

// ==========================================================
// timing
`define RTCAW_CORE_HZ 50000000
`define RTCAW_OSC_HZ 32768
`define RTCAW_SEC_TICKS 32768
`define RTCAW_CAL_SHORT 128
`define RTCAW_CAL_LONG 256
`define RTCAW_SEC_PER_MIN 60
`define RTCAW_PULSE_MS 200

`endif

// ==== verilog/rtcaw_pkg.sv ====
package rtcaw_pkg;

// ==========================================================
// complete state of the core
typedef struct packed {
    logic [25:0] acc;
    logic osc_tick;
    logic sq32;
    logic [14:0] div;
    logic [16:0] pre;
    logic [5:0] sec_in_min;
    logic [5:0] min_idx;
    logic sec_tick;
    logic watchdog_expired_flag;
    logic af;
    logic pf;
    logic cal;
    logic wen;
    logic rdb;
    logic [3:0][7:0] alm_stage;
    logic [3:0][7:0] alm_act;
    logic alm_prev;
    logic [7:0] irq_ctl;
    logic wd_lock;
    logic [5:0] wd_timeout;
    logic [5:0] wd_cnt;
    logic [7:0] trim;
    logic bk_s1;
    logic bk_s2;
    logic sd_s1;
    logic sd_s2;
    logic sd_prev;
    logic irq_prev;
    logic [12:0] pulse_cnt;
    logic [7:0] rdata;
    logic int_out;
    logic int_oe;
} rtcaw_state_t;

endpackage

// ==== verilog/rtcaw_core.sv ====
`timescale 1ns/1ns
`include "rtcaw_consts.svh"

module rtcaw_core
    import rtcaw_pkg::*;
#(
    parameter int CORE_HZ = `RTCAW_CORE_HZ,
    parameter int OSC_HZ = `RTCAW_OSC_HZ,
    parameter int PULSE_TICKS = `RTCAW_PULSE_MS * `RTCAW_OSC_HZ / 1000
)(
    input logic core_clk,
    input logic rst_n,
    input logic [3:0] reg_addr,
    input logic [7:0] reg_wdata,
    input logic reg_wr,
    input logic reg_rd,
    output logic [7:0] reg_rdata,
    input logic [7:0] time_sec,
    input logic [7:0] time_min,
    input logic [7:0] time_hour,
    input logic [7:0] time_date,
    input logic on_backup,
    input logic supply_drop,
    output logic sec_tick,
    output logic int_out,
    output logic int_oe
);

// ==========================================================
// alarm field compare
localparam logic [3:0][6:0] FIELD_MASK = {7'h3f, 7'h3f, 7'h7f, 7'h7f};
localparam logic [16:0] SEC_LAST = 17'(`RTCAW_SEC_TICKS - 1);
localparam logic [16:0] SEC_SHORT =
    17'(`RTCAW_SEC_TICKS - `RTCAW_CAL_SHORT - 1);
localparam logic [16:0] SEC_LONG =
    17'(`RTCAW_SEC_TICKS + `RTCAW_CAL_LONG - 1);

rtcaw_state_t st_reg;
rtcaw_state_t st_next;
logic [3:0] alm_hit;
logic [3:0][6:0] now_val;

assign now_val = {time_date[6:0], time_hour[6:0], time_min[6:0],
                  time_sec[6:0]};

genvar gi;
generate
    for (gi = 0; gi < 4; gi++)
    begin : g_alm
        // a set match bit drops the field from the compare
        assign alm_hit[gi] = st_reg.alm_act[gi][`RTCAW_ALM_MATCH] |
            ((st_reg.alm_act[gi][6:0] & FIELD_MASK[gi]) ==
             (now_val[gi] & FIELD_MASK[gi]));
    end
endgenerate

// ==========================================================
// next state
always_comb
begin
    logic [26:0] acc_sum;
    logic [16:0] sec_last;
    logic wd_tick;
    logic flags_rd;
    logic irq_cond;
    logic lvl;
    logic wave;
    logic [1:0] aidx;
    acc_sum = 27'h0;
    sec_last = SEC_LAST;
    wd_tick = 1'b0;
    flags_rd = 1'b0;
    irq_cond = 1'b0;
    lvl = 1'b0;
    wave = 1'b0;
    aidx = 2'(reg_addr - `RTCAW_OFS_ALM_SEC);
    st_next = st_reg;
    st_next.osc_tick = 1'b0;
    st_next.sec_tick = 1'b0;

    // pin synchronisers
    st_next.bk_s1 = on_backup;
    st_next.bk_s2 = st_reg.bk_s1;
    st_next.sd_s1 = supply_drop;
    st_next.sd_s2 = st_reg.sd_s1;
    st_next.sd_prev = st_reg.sd_s2;

    // oscillator tick from core clock by phase accumulation
    acc_sum = {1'b0, st_reg.acc} + 27'(OSC_HZ);
    if (acc_sum >= 27'(CORE_HZ))
    begin
        st_next.acc = 26'(acc_sum - 27'(CORE_HZ));
        st_next.osc_tick = 1'b1;
    end
    else
    begin
        st_next.acc = acc_sum[25:0];
    end
    st_next.sq32 = st_reg.acc >= 26'(CORE_HZ / 2);

    // calibrated second divider
    if (st_reg.min_idx < {st_reg.trim[4:0], 1'b0} &&
        st_reg.sec_in_min == 6'h00)
    begin
        sec_last = st_reg.trim[`RTCAW_TRIM_SIGN] ? SEC_LONG
                                                  : SEC_SHORT;
    end
    if (st_reg.osc_tick)
    begin
        st_next.div = st_reg.div + 15'h1;
        if (st_reg.pre >= sec_last)
        begin
            st_next.pre = 17'h0;
            st_next.sec_tick = 1'b1;
            if (st_reg.sec_in_min == 6'(`RTCAW_SEC_PER_MIN - 1))
            begin
                st_next.sec_in_min = 6'h00;
                st_next.min_idx = st_reg.min_idx + 6'h1;
            end
            else
            begin
                st_next.sec_in_min = st_reg.sec_in_min + 6'h1;
            end
        end
        else
        begin
            st_next.pre = st_reg.pre + 17'h1;
        end
    end
    wd_tick = st_reg.osc_tick && st_reg.div[9:0] == 10'h3ff;

    // register reads
    flags_rd = reg_rd && reg_addr == `RTCAW_OFS_FLAGS;
    if (reg_rd)
    begin
        case (reg_addr)
            `RTCAW_OFS_FLAGS: st_next.rdata = {st_reg.watchdog_expired_flag, st_reg.af,
                st_reg.pf, 2'b00, st_reg.cal, st_reg.wen, st_reg.rdb};
            `RTCAW_OFS_ALM_SEC, `RTCAW_OFS_ALM_MIN, `RTCAW_OFS_ALM_HOUR,
            `RTCAW_OFS_ALM_DATE: st_next.rdata = st_reg.alm_stage[aidx];
            `RTCAW_OFS_IRQ: st_next.rdata = st_reg.irq_ctl;
            `RTCAW_OFS_WDOG: st_next.rdata = {1'b0, st_reg.wd_lock,
                st_reg.wd_timeout};
            `RTCAW_OFS_TRIM: st_next.rdata = {st_reg.trim[7], 1'b0,
                st_reg.trim[5:0]};
            default: st_next.rdata = 8'h00;
        endcase
    end
    if (flags_rd)
    begin
        st_next.watchdog_expired_flag = 1'b0;
        st_next.af = 1'b0;
        st_next.pf = 1'b0;
    end

    // register writes
    if (reg_wr)
    begin
        case (reg_addr)
            `RTCAW_OFS_FLAGS:
            begin
                st_next.wen = reg_wdata[`RTCAW_FLG_WEN];
                st_next.rdb = reg_wdata[`RTCAW_FLG_RD];
                if (st_reg.wen)
                begin
                    st_next.cal = reg_wdata[`RTCAW_FLG_CAL];
                    if (!reg_wdata[`RTCAW_FLG_WEN])
                    begin
                        st_next.alm_act = st_reg.alm_stage;
                    end
                end
            end
            `RTCAW_OFS_ALM_SEC, `RTCAW_OFS_ALM_MIN, `RTCAW_OFS_ALM_HOUR,
            `RTCAW_OFS_ALM_DATE:
            begin
                if (st_reg.wen)
                begin
                    st_next.alm_stage[aidx] = reg_wdata;
                end
            end
            `RTCAW_OFS_IRQ: st_next.irq_ctl = reg_wdata;
            `RTCAW_OFS_WDOG:
            begin
                st_next.wd_lock = reg_wdata[`RTCAW_WD_LOCK];
                if (!reg_wdata[`RTCAW_WD_LOCK])
                begin
                    st_next.wd_timeout = reg_wdata[5:0];
                end
            end
            `RTCAW_OFS_TRIM: st_next.trim = {reg_wdata[7], 1'b0,
                reg_wdata[5:0]};
            default: st_next.rdb = st_reg.rdb;
        endcase
    end

    // watchdog down-counter
    if (wd_tick && st_reg.wd_timeout != 6'h00)
    begin
        if (st_reg.wd_cnt == 6'h01)
        begin
            st_next.watchdog_expired_flag = 1'b1;
            st_next.wd_cnt = st_reg.wd_timeout;
        end
        else if (st_reg.wd_cnt == 6'h00)
        begin
            st_next.wd_cnt = st_reg.wd_timeout;
        end
        else
        begin
            st_next.wd_cnt = st_reg.wd_cnt - 6'h1;
        end
    end
    if (reg_wr && reg_addr == `RTCAW_OFS_WDOG &&
        reg_wdata[`RTCAW_WD_KICK])
    begin
        st_next.wd_cnt = st_next.wd_timeout;
    end

    // event flags, set wins over read clear
    st_next.alm_prev = &alm_hit;
    if ((&alm_hit) && !st_reg.alm_prev)
    begin
        st_next.af = 1'b1;
    end
    if (st_reg.sd_s2 && !st_reg.sd_prev)
    begin
        st_next.pf = 1'b1;
    end

    // interrupt condition and pulse stretcher
    irq_cond = !st_reg.bk_s2 &&
        ((st_reg.watchdog_expired_flag && st_reg.irq_ctl[`RTCAW_IRQ_WIE]) ||
         (st_reg.af && st_reg.irq_ctl[`RTCAW_IRQ_AIE]) ||
         (st_reg.pf && st_reg.irq_ctl[`RTCAW_IRQ_PFE]));
    st_next.irq_prev = irq_cond;
    if (flags_rd || st_reg.bk_s2)
    begin
        st_next.pulse_cnt = 13'h0;
    end
    else if (irq_cond && !st_reg.irq_prev)
    begin
        st_next.pulse_cnt = 13'(PULSE_TICKS);
    end
    else if (st_reg.osc_tick && st_reg.pulse_cnt != 13'h0)
    begin
        st_next.pulse_cnt = st_reg.pulse_cnt - 13'h1;
    end
    lvl = st_reg.irq_ctl[`RTCAW_IRQ_PL] ? st_reg.pulse_cnt != 13'h0
                                        : irq_cond;

    // pin source selection and driver mode
    if (st_reg.cal)
    begin
        wave = st_reg.div[5];
    end
    else if (st_reg.irq_ctl[`RTCAW_IRQ_SQUARE_OUTPUT_ENABLE])
    begin
        unique case (st_reg.irq_ctl[1:0])
            2'b00: wave = st_reg.div[14];
            2'b01: wave = st_reg.div[5];
            2'b10: wave = st_reg.div[2];
            2'b11: wave = st_reg.sq32;
        endcase
    end
    else
    begin
        wave = lvl;
    end
    if (st_reg.bk_s2)
    begin
        st_next.int_out = 1'b0;
        st_next.int_oe = 1'b0;
    end
    else if (st_reg.irq_ctl[`RTCAW_IRQ_HL])
    begin
        st_next.int_out = wave;
        st_next.int_oe = 1'b1;
    end
    else
    begin
        st_next.int_out = 1'b0;
        st_next.int_oe = wave;
    end
end

// ==========================================================
// state register
always_ff @(posedge core_clk or negedge rst_n)
begin
    if (!rst_n)
    begin
        st_reg <= '0;
        st_reg.irq_ctl <= `RTCAW_RST_IRQ;
        st_reg.trim <= `RTCAW_RST_TRIM;
        st_reg.wd_timeout <= `RTCAW_RST_WDOG;
        st_reg.wd_cnt <= `RTCAW_RST_WDOG;
        st_reg.alm_stage <= {4{`RTCAW_RST_ALM}};
        st_reg.alm_act <= {4{`RTCAW_RST_ALM}};
    end
    else
    begin
        st_reg <= st_next;
    end
end

assign reg_rdata = st_reg.rdata;
assign sec_tick = st_reg.sec_tick;
assign int_out = st_reg.int_out;
assign int_oe = st_reg.int_oe;

endmodule // rtcaw_core

// ==== dv/rtcaw_core_monitor.sv ====
`timescale 1ns/1ns
// ========================================
// port checker
module rtcaw_core_monitor #(
    parameter int CORE_HZ = 50000000,
    parameter int OSC_HZ = 32768,
    parameter int PULSE_TICKS = 6553
)(
    input logic core_clk,
    input logic rst_n,
    input logic [3:0] reg_addr,
    input logic [7:0] reg_wdata,
    input logic reg_wr,
    input logic reg_rd,
    input logic [7:0] reg_rdata,
    input logic on_backup,
    input logic sec_tick,
    input logic int_out,
    input logic int_oe
);
    localparam int PMAX = PULSE_TICKS * (CORE_HZ / OSC_HZ) + 4;
    logic [7:0] irq_sh;
    logic w_sh;
    logic cal_sh;
    logic [15:0] act_cnt;
    wire act = irq_sh[3] ? int_out : int_oe;
    wire fl_rd = reg_rd && reg_addr == 4'h0;
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            irq_sh <= 8'h08;
            w_sh <= 1'b0;
            cal_sh <= 1'b0;
            act_cnt <= 16'h0000;
        end
        else
        begin
            act_cnt <= act ? act_cnt + 16'h0001 : 16'h0000;
            if (reg_wr && reg_addr == 4'h6)
                irq_sh <= reg_wdata;
            if (reg_wr && reg_addr == 4'h0)
                w_sh <= reg_wdata[1];
            if (reg_wr && reg_addr == 4'h0 && w_sh)
                cal_sh <= reg_wdata[2];
        end
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    a_backup_no_drive: assert property (on_backup [*4] |-> !int_oe)
        else $error("pin driven on backup");
    a_never_float_high: assert property (int_out |-> int_oe)
        else $error("high level not driven");
    a_drain_stays_low: assert property (!irq_sh[3] [*3] |-> !int_out)
        else $error("open drain drove high");
    a_push_pull_on: assert property ((irq_sh[3] && !on_backup) [*5] |-> int_oe)
        else $error("push pull not driving");
    a_pulse_width_cap: assert property (irq_sh[2] && !irq_sh[4] && !cal_sh
        |-> act_cnt <= PMAX)
        else $error("pulse too long");
    a_quiet_no_enable: assert property ((irq_sh[7:2] == 6'h02 && !cal_sh) [*3]
        |-> !act)
        else $error("pin active without enable");
    a_read_ends_irq: assert property (fl_rd && !irq_sh[4] && !cal_sh
        |-> ##2 !act)
        else $error("pin still active after flags read");
    a_tick_single: assert property (sec_tick |=> !sec_tick [*8])
        else $error("second tick too close");
    a_flags_cleared: assert property (fl_rd ##2 fl_rd
        |=> reg_rdata[7:5] == 3'h0)
        else $error("flags not cleared by read");
    c_pulse: cover property (irq_sh[2] && act);
    c_cal_test: cover property (cal_sh && int_out);
    c_second: cover property (sec_tick);
endmodule // rtcaw_core_monitor

// ==== dv/rtcaw_host.sv ====
`timescale 1ns/1ns
// ========================================
// host side of the interrupt pin
module rtcaw_host #(
    parameter int BLANK = 16
)(
    input logic core_clk,
    input logic rst_n,
    input logic int_out,
    input logic int_oe,
    output logic pin,
    output logic armed
);
    int blank_cnt;
    // pull-up when not driven
    assign pin = int_oe ? int_out : 1'b1;
    assign armed = blank_cnt == 0;
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            blank_cnt <= BLANK;
        else if (blank_cnt > 0)
            blank_cnt <= blank_cnt - 1;
    end
endmodule // rtcaw_host

// ==== dv/rtcaw_core_test.sv ====
`timescale 1ns/1ns
module rtcaw_core_test;
    localparam int CORE_HZ = 50000000;
    localparam int OSC_HZ = 25000000;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic on_backup = 1'b0;
    logic supply_drop = 1'b0;
    logic [7:0] time_sec = 8'h00, time_min = 8'h00, time_hour = 8'h00;
    logic [7:0] time_date = 8'h01;
    logic [7:0] reg_rdata, s;
    logic sec_tick, int_out, int_oe, pin, armed;
    logic [7:0] m [16];
    logic wen = 1'b0;
    int mismatches = 0, checks_done = 0, cyc = 0, t0 = 0, t1 = 0, n;
    always #10 core_clk = ~core_clk;
    always @(posedge core_clk) cyc <= cyc + 1;
    rtcaw_core #(.CORE_HZ(CORE_HZ), .OSC_HZ(OSC_HZ), .PULSE_TICKS(8))
    u_rtcaw_core (.core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .time_sec(time_sec), .time_min(time_min),
        .time_hour(time_hour), .time_date(time_date), .on_backup(on_backup),
        .supply_drop(supply_drop), .sec_tick(sec_tick), .int_out(int_out),
        .int_oe(int_oe));
    rtcaw_host u_rtcaw_host (.core_clk(core_clk), .rst_n(rst_n),
        .int_out(int_out), .int_oe(int_oe), .pin(pin), .armed(armed));
    task automatic final_report;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(string nm, logic [7:0] e, logic [7:0] g);
        checks_done++;
        if (g !== e)
        begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic idle(int c);
        repeat (c) @(posedge core_clk);
        #1;
    endtask
    // ========================================
    // register access and register model
    task automatic wr(logic [3:0] a, logic [7:0] d);
        idle(1);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        idle(1);
        reg_wr = 1'b0;
        if (a > 4'h1 && a < 4'h6 && wen)
            m[a] = d;
        if (a == 4'h6)
            m[6] = d;
        if (a == 4'h7)
            m[7] = {1'b0, d[6], d[6] ? m[7][5:0] : d[5:0]};
        if (a == 4'h8)
            m[8] = d & 8'hbf;
        if (a == 4'h0)
            wen = d[1];
    endtask
    task automatic rd(logic [3:0] a, logic [7:0] e);
        idle(1);
        reg_addr = a;
        reg_rd = 1'b1;
        idle(1);
        reg_rd = 1'b0;
        chk("reg_rdata", e, reg_rdata);
    endtask
    task automatic wait_pin(logic lv, int lim);
        int k = 0;
        while (pin !== lv && k < lim)
        begin
            idle(1);
            k++;
        end
        chk("pin", 8'(lv), 8'(pin));
    endtask
    task automatic dur(logic lv, output int c);
        wait_pin(lv, 200);
        c = 0;
        while (pin === lv && c < 200)
        begin
            idle(1);
            c++;
        end
    endtask
    initial
    begin
        #1900000;
        mismatches++;
        final_report;
    end
    initial
    begin
        @(posedge rst_n);
        t0 = cyc;
        @(posedge sec_tick);
        t1 = cyc;
    end
    // ========================================
    // main sequence
    initial
    begin
        void'($urandom(6));
        for (int i = 0; i < 16; i++)
            m[i] = (i == 6) ? 8'h08 : 8'h00;
        idle(20);
        rst_n = 1'b1;
        for (int a = 0; a < 10; a++)
            rd(4'(a), m[a]);
        wr(4'h8, 8'h21);
        wr(4'h9, 8'($urandom));
        for (int a = 7; a < 10; a++)
            rd(4'(a), m[a]);
        supply_drop = 1'b1;
        idle(6);
        chk("pin", 8'h00, 8'(pin));
        rd(4'h0, 8'h20);
        supply_drop = 1'b0;
        wr(4'h6, 8'h88);
        wr(4'h7, 8'h02);
        wr(4'h7, 8'h7f);
        rd(4'h7, m[7]);
        repeat (6)
        begin
            idle(1500);
            wr(4'h7, 8'hc0);
        end
        rd(4'h0, 8'h00);
        wait_pin(1'b1, 4300);
        rd(4'h0, 8'h80);
        rd(4'h0, 8'h00);
        chk("pin", 8'h00, 8'(pin));
        wr(4'h7, 8'h00);
        rd(4'h0, 8'h00);
        idle(6000);
        rd(4'h0, 8'h00);
        s = {1'b0, 3'($urandom_range(5)), 4'($urandom_range(9))};
        wr(4'h0, 8'h02);
        wr(4'h2, s);
        wr(4'h3, 8'h80 | 8'($urandom_range(89)));
        wr(4'h4, 8'h80);
        wr(4'h5, 8'h80);
        rd(4'h3, m[3]);
        time_sec = s;
        idle(6);
        rd(4'h0, 8'h02);
        time_sec = s ^ 8'h01;
        wr(4'h0, 8'h00);
        wr(4'h6, 8'h44);
        idle(4);
        time_min = 8'($urandom_range(89));
        time_sec = s;
        dur(1'b0, n);
        chk("pulse", 8'h01, 8'(n >= 14 && n <= 20));
        rd(4'h0, 8'h40);
        time_sec = s ^ 8'h01;
        idle(2);
        time_sec = s;
        wait_pin(1'b0, 8);
        rd(4'h0, 8'h40);
        idle(1);
        chk("pin", 8'h01, 8'(pin));
        for (int f = 1; f < 4; f++)
        begin
            wr(4'h6, 8'h18 | 8'(f));
            wait_pin(1'b0, 200);
            dur(1'b1, n);
            chk("half", 8'(32768 >> (3 * f + 6)), 8'(n));
        end
        wr(4'h0, 8'h02);
        wr(4'h0, 8'h06);
        wr(4'h0, 8'h04);
        wr(4'h8, 8'h3f);
        wait_pin(1'b0, 200);
        dur(1'b1, n);
        chk("half", 8'h40, 8'(n));
        wr(4'h0, 8'h02);
        wr(4'h0, 8'h00);
        on_backup = 1'b1;
        idle(6);
        chk("int_oe", 8'h00, 8'(int_oe));
        on_backup = 1'b0;
        while (t1 == 0)
            idle(1);
        n = t1 - t0;
        chk("second", 8'h01, 8'(n >= 66040 && n <= 66060));
        final_report;
    end
endmodule // rtcaw_core_test
bind rtcaw_core rtcaw_core_monitor #(.CORE_HZ(CORE_HZ), .OSC_HZ(OSC_HZ),
    .PULSE_TICKS(PULSE_TICKS)) u_rtcaw_core_monitor (.core_clk(core_clk),
    .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .on_backup(on_backup), .sec_tick(sec_tick), .int_out(int_out),
    .int_oe(int_oe));
